// ### logic/sza_access_ctrl.sv
// access control core for a serial secure card memory, axi4-lite port
// assumes software issues one command at a time via the command register
`timescale 1ns/1ps
module sza_access_ctrl
    import sza_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // axi4-lite write address and data
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////
    // state declarations
    sza_state_e       state;
    sza_state_e       next_state;
    logic [ADR_W-1:0] ctr;
    logic [ADR_W-1:0] next_ctr;
    logic [ADR_W-1:0] walk;
    logic [ADR_W-1:0] next_walk;
    logic [ADR_W-1:0] wend;
    logic [ADR_W-1:0] next_wend;
    logic [2:0]       op;
    logic [2:0]       next_op;
    logic             cdat;
    logic             next_cdat;
    logic             security_validated_flag;
    logic             next_valid;
    logic             zone3_key_valid_flag;
    logic             next_keyok;
    logic             cmp_ok;
    logic             next_cmp;
    logic             data_bit;
    logic             next_data;
    logic             refused;
    logic             next_ref;

    logic             aw_got;
    logic             next_aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic [AXI_AW-1:0] next_aw_addr;
    logic             w_got;
    logic             next_w_got;
    logic [31:0]      w_data;
    logic [31:0]      next_w_data;
    logic [3:0]       w_strb;
    logic [3:0]       next_w_strb;
    logic             next_awready;
    logic             next_wready;
    logic             next_bvalid;
    logic [1:0]       next_bresp;
    logic             next_arready;
    logic             next_rvalid;
    logic [31:0]      next_rdata;
    logic [1:0]       next_rresp;
    logic             cmd_go;

    // memory port
    logic             mem_we;
    logic [ADR_W-1:0] mem_wa;
    logic             mem_wd;
    logic             rd;
    logic             issuer_fuse;
    logic             zone2_erase_limit_fuse;
    logic             mfg_fuse;
    logic             zone3_write_permit;
    logic             zone3_read_permit;

    sza_bit_mem u_mem (
        .ref_clk                (ref_clk),
        .rst                    (rst),
        .we                     (mem_we),
        .waddr                  (mem_wa),
        .wdata                  (mem_wd),
        .raddr                  (ctr),
        .rdata                  (rd),
        .issuer_fuse            (issuer_fuse),
        .zone2_erase_limit_fuse (zone2_erase_limit_fuse),
        .mfg_fuse               (mfg_fuse),
        .zone3_write_permit     (zone3_write_permit),
        .zone3_read_permit      (zone3_read_permit)
    );

    ////////////////////////////////////////////////////////////////////////
    // access predicates, from the current counter, fuse taps, security flags and read data
    logic             mode2;
    logic             in_manz;
    logic             in_z3;
    logic             in_cfg;
    logic             in_unused;
    logic             manz_open;
    logic             z3_erase_ok;
    logic             wr_ok;
    logic             rd_ok;
    logic             match;
    logic [ADR_W-1:0] ctr_inc;
    logic [ADR_W-1:0] word_base;

    assign mode2     = ~issuer_fuse;
    assign in_manz   = (ctr >= MANZ_FIRST) && (ctr <= MANZ_LAST);
    assign in_z3     = (ctr >= Z3_FIRST) && (ctr <= Z3_LAST);
    assign in_cfg    = (ctr >= CFG_FIRST) && (ctr <= Z3_KEY);
    assign in_unused = (ctr >= UNUSED_FIRST);
    // either fuse blown shuts the zone; with both fuses intact a code match opens it
    assign manz_open = security_validated_flag & mfg_fuse
                     & issuer_fuse;
    // no erase counter exists for zone three, so no limit is applied
    assign z3_erase_ok = security_validated_flag
                       & (~mode2 | zone3_key_valid_flag);
    assign match     = (rd == cdat);
    assign ctr_inc   = (ctr == ADDR_LAST) ? ADDR_ZERO
                                          : ctr + ADDR_ONE;
    assign word_base = ctr & ~WORD_MASK;

    always_comb begin
        if (in_z3) begin
            wr_ok = security_validated_flag
                  & (~mode2 | zone3_write_permit);
        end else if (in_manz) begin
            wr_ok = manz_open;
        end else if (in_cfg && ctr != ISSUER_FUSE && ctr != MFG_FUSE) begin
            // limit fuse and erase key freeze once the issuer fuse blows
            wr_ok = security_validated_flag & ~mode2;
        end else begin
            wr_ok = security_validated_flag;
        end
        if (in_z3) begin
            rd_ok = zone3_read_permit | security_validated_flag;
        end else begin
            rd_ok = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command engine
    always_comb begin
        next_state = state;
        next_ctr   = ctr;
        next_walk  = walk;
        next_wend  = wend;
        next_op    = op;
        next_cdat  = cdat;
        next_valid = security_validated_flag;
        next_keyok = zone3_key_valid_flag;
        next_cmp   = cmp_ok;
        next_data  = data_bit;
        next_ref   = refused;
        mem_we     = 1'b0;
        mem_wa     = ctr;
        mem_wd     = 1'b0;
        case (state)
            SZA_IDLE: begin
                if (cmd_go) begin
                    next_op    = w_data[CMD_OP_LSB +: 3];
                    next_cdat  = w_data[CMD_DATA_BIT];
                    next_state = SZA_EXEC;
                end
            end
            SZA_EXEC: begin
                next_state = SZA_IDLE;
                next_ref   = 1'b0;
                case (op)
                    OP_RESET: begin
                        next_ctr = ADDR_ZERO;
                    end
                    OP_INC: begin
                        next_ctr = ctr_inc;
                    end
                    OP_CMP: begin
                        next_ctr = ctr_inc;
                        if (ctr == SC_FIRST) begin
                            next_cmp = match;
                        end else if (ctr > SC_FIRST && ctr <= SC_LAST) begin
                            next_cmp = cmp_ok & match;
                        end
                        if (ctr == SC_LAST && cmp_ok && match) begin
                            next_valid = 1'b1;
                        end
                        if (ctr == Z3_KEY && match && mode2
                            && security_validated_flag) begin
                            next_keyok = 1'b1;
                        end
                    end
                    OP_READ: begin
                        next_data = rd_ok & rd;
                        next_ref  = ~rd_ok;
                    end
                    OP_WRITE: begin
                        if (in_unused) begin
                            next_ref = 1'b0;
                        end else if (wr_ok) begin
                            mem_we = 1'b1;
                        end else begin
                            next_ref = 1'b1;
                        end
                    end
                    OP_ERASE: begin
                        if (in_unused) begin
                            next_ref = 1'b0;
                        end else if (in_z3 || ctr == Z3_TRIGGER) begin
                            if (z3_erase_ok) begin
                                // trigger bit after key check wipes zone
                                next_walk  = Z3_FIRST;
                                next_wend  = Z3_LAST;
                                next_state = SZA_WALK;
                            end else begin
                                next_ref = 1'b1;
                            end
                        end else if (ctr == Z3_KEY) begin
                            if (security_validated_flag && !mode2) begin
                                mem_we = 1'b1;
                                mem_wd = 1'b1;
                            end else begin
                                next_ref = 1'b1;
                            end
                        end else if (in_manz ? manz_open
                                   : in_cfg ? security_validated_flag
                                              & ~mode2
                                   : security_validated_flag) begin
                            // outside app zones an erase covers a word
                            next_walk  = word_base;
                            next_wend  = word_base | WORD_MASK;
                            next_state = SZA_WALK;
                        end else begin
                            next_ref = 1'b1;
                        end
                    end
                    default: begin
                        next_ref = 1'b1;
                    end
                endcase
            end
            SZA_WALK: begin
                // one bit per clock: slow, but keeps a single write port
                mem_we = 1'b1;
                mem_wa = walk;
                mem_wd = 1'b1;
                if (walk == wend) begin
                    next_state = SZA_IDLE;
                end else begin
                    next_walk = walk + ADDR_ONE;
                end
            end
            default: begin
                next_state = SZA_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state                   <= SZA_IDLE;
            ctr                     <= ADDR_ZERO;
            walk                    <= ADDR_ZERO;
            wend                    <= ADDR_ZERO;
            op                      <= OP_RESET;
            cdat                    <= 1'b0;
            security_validated_flag <= 1'b0;
            zone3_key_valid_flag    <= 1'b0;
            cmp_ok                  <= 1'b0;
            data_bit                <= 1'b0;
            refused                 <= 1'b0;
        end else begin
            state                   <= next_state;
            ctr                     <= next_ctr;
            walk                    <= next_walk;
            wend                    <= next_wend;
            op                      <= next_op;
            cdat                    <= next_cdat;
            security_validated_flag <= next_valid;
            zone3_key_valid_flag    <= next_keyok;
            cmp_ok                  <= next_cmp;
            data_bit                <= next_data;
            refused                 <= next_ref;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    logic w_fire;
    assign w_fire = aw_got & w_got & ~s_axi_bvalid;
    // a command while busy is dropped; software polls the busy bit
    assign cmd_go = w_fire && (aw_addr == REG_CMD) && w_strb[0]
                 && (state == SZA_IDLE);

    always_comb begin
        next_aw_got  = aw_got;
        next_aw_addr = aw_addr;
        next_w_got   = w_got;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got  = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got  = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (w_fire) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = (aw_addr == REG_CMD || aw_addr == REG_STATUS
                           || aw_addr == REG_ADDR) ? RESP_OKAY
                                                   : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = ~next_aw_got & ~next_bvalid;
        next_wready  = ~next_w_got & ~next_bvalid;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_got        <= 1'b0;
            aw_addr       <= '0;
            w_got         <= 1'b0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            aw_got        <= next_aw_got;
            aw_addr       <= next_aw_addr;
            w_got         <= next_w_got;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    logic [31:0] status_word;
    always_comb begin
        status_word              = '0;
        status_word[ST_BUSY]     = (state != SZA_IDLE);
        status_word[ST_VALID]    = security_validated_flag;
        status_word[ST_KEYOK]    = zone3_key_valid_flag;
        status_word[ST_MODE2]    = mode2;
        status_word[ST_DATA]     = data_bit;
        status_word[ST_REFUSED]  = refused;
        status_word[ST_Z2_LIMIT] = mode2 & zone2_erase_limit_fuse;
        status_word[ST_MANZ_LOCK] = ~(mfg_fuse & issuer_fuse);
    end

    always_comb begin
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        next_arready = s_axi_arready;
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            case (s_axi_araddr)
                REG_STATUS: next_rdata = status_word;
                REG_ADDR:   next_rdata = {21'h000000, ctr};
                REG_CMD:    next_rdata = {27'h0000000, cdat, 1'b0, op};
                default: begin
                    next_rdata = '0;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end else if (!s_axi_rvalid) begin
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end
endmodule

// ### logic/sza_pkg.sv
// constants for the secure zone access control block
// assumes a single 100 MHz clock and an axi4-lite register port
package sza_pkg;
    localparam int unsigned AXI_AW          = 12;
    localparam int unsigned ADR_W           = 11;
    localparam int unsigned MEM_BITS        = 1600;
    // register byte offsets
    localparam logic [11:0] REG_CMD         = 12'h000;
    localparam logic [11:0] REG_STATUS      = 12'h004;
    localparam logic [11:0] REG_ADDR        = 12'h008;
    // command field layout and codes
    localparam int unsigned CMD_OP_LSB      = 0;
    localparam int unsigned CMD_DATA_BIT    = 4;
    localparam logic [2:0]  OP_RESET        = 3'h0;
    localparam logic [2:0]  OP_INC          = 3'h1;
    localparam logic [2:0]  OP_CMP          = 3'h2;
    localparam logic [2:0]  OP_READ         = 3'h3;
    localparam logic [2:0]  OP_WRITE        = 3'h4;
    localparam logic [2:0]  OP_ERASE        = 3'h5;
    // status bit positions
    localparam int unsigned ST_BUSY         = 0;
    localparam int unsigned ST_VALID        = 1;
    localparam int unsigned ST_KEYOK        = 2;
    localparam int unsigned ST_MODE2        = 3;
    localparam int unsigned ST_DATA         = 4;
    localparam int unsigned ST_REFUSED      = 5;
    localparam int unsigned ST_Z2_LIMIT     = 6;
    localparam int unsigned ST_MANZ_LOCK    = 7;
    // bit address map
    localparam logic [10:0] MANZ_FIRST      = 11'h010;
    localparam logic [10:0] MANZ_LAST       = 11'h04f;
    localparam logic [10:0] SC_FIRST        = 11'h050;
    localparam logic [10:0] SC_LAST         = 11'h05f;
    localparam logic [10:0] Z3_FIRST        = 11'h400;
    localparam logic [10:0] Z3_LAST         = 11'h5ff;
    localparam logic [10:0] Z3_WPERMIT      = 11'h400;
    localparam logic [10:0] Z3_RPERMIT      = 11'h401;
    localparam logic [10:0] CFG_FIRST       = 11'h600;
    localparam logic [10:0] ISSUER_FUSE     = 11'h600;
    localparam logic [10:0] LIMIT_FUSE      = 11'h610;
    localparam logic [10:0] MFG_FUSE        = 11'h614;
    localparam logic [10:0] Z3_KEY          = 11'h62f;
    localparam logic [10:0] Z3_TRIGGER      = 11'h630;
    localparam logic [10:0] UNUSED_FIRST    = 11'h631;
    localparam logic [10:0] ADDR_LAST       = 11'h63f;
    localparam logic [10:0] ADDR_ZERO       = 11'h000;
    localparam logic [10:0] ADDR_ONE        = 11'h001;
    localparam logic [10:0] WORD_MASK       = 11'h00f;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        SZA_IDLE = 2'h0,
        SZA_EXEC = 2'h1,
        SZA_WALK = 2'h3
    } sza_state_e;
endpackage

// ### logic/sza_bit_mem.sv
// bit-wide storage array for the card memory, all bits erased at reset
// assumes one write per clock; read data registered one clock late
`timescale 1ns/1ps
module sza_bit_mem
    import sza_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // write port
    input  wire logic              we,
    input  wire logic [ADR_W-1:0]  waddr,
    input  wire logic              wdata,
    // read port
    input  wire logic [ADR_W-1:0]  raddr,
    output logic                   rdata,
    // fuse and permission taps
    output logic                   issuer_fuse,
    output logic                   zone2_erase_limit_fuse,
    output logic                   mfg_fuse,
    output logic                   zone3_write_permit,
    output logic                   zone3_read_permit
);
    logic [MEM_BITS-1:0] bits;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bits  <= '1;
            rdata <= 1'b1;
        end else begin
            if (we) begin
                bits[waddr] <= wdata;
            end
            rdata <= bits[raddr];
        end
    end

    assign issuer_fuse            = bits[ISSUER_FUSE];
    assign zone2_erase_limit_fuse = bits[LIMIT_FUSE];
    assign mfg_fuse               = bits[MFG_FUSE];
    assign zone3_write_permit     = bits[Z3_WPERMIT];
    assign zone3_read_permit      = bits[Z3_RPERMIT];
endmodule

// ### verif/sza_ctrl_asserts.sv
// axi4-lite port checks for the access control block
// bound to sza_access_ctrl, sees only its ports
`timescale 1ns/1ps
module sza_ctrl_asserts
    import sza_pkg::*;
(
    // clock, reset and axi4-lite port
    input wire logic              ref_clk, rst,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_bresp, s_axi_rresp,
    input wire logic              s_axi_awvalid, s_axi_awready,
    input wire logic              s_axi_wvalid, s_axi_wready,
    input wire logic              s_axi_bvalid, s_axi_bready,
    input wire logic              s_axi_arvalid, s_axi_arready,
    input wire logic              s_axi_rvalid, s_axi_rready
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no b");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no r");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b moved");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r moved");
    a_write_closed: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("w open");
    a_read_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar open");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > REG_ADDR |=> s_axi_rresp == RESP_SLVERR &&
        s_axi_rdata == 32'h0) else $error("bad unmapped read");
    a_mapped_okay: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == REG_STATUS |=> s_axi_rresp == RESP_OKAY)
        else $error("bad status read");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_error: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind sza_access_ctrl sza_ctrl_asserts u_chk (.*);

// ### verif/sza_rdr.sv
// reader model: issues axi4-lite transfers one at a time
// raises hung when the block never answers
`timescale 1ns/1ps
module sza_rdr
    import sza_pkg::*;
(
    // clock
    input wire logic               ref_clk,
    // requests
    output logic [AXI_AW-1:0]      s_axi_awaddr, s_axi_araddr,
    output logic [31:0]            s_axi_wdata,
    output logic                   s_axi_awvalid, s_axi_wvalid,
    output logic                   s_axi_bready, s_axi_arvalid,
    output logic                   s_axi_rready, hung,
    // answers
    input wire logic               s_axi_awready, s_axi_wready,
    input wire logic               s_axi_bvalid, s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid
);
    initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid,
        s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hung} = '0;
    // w selects write; read data comes back through d
    task automatic xfer(input logic w, input logic [11:0] a,
                        inout logic [31:0] d);
        @(posedge ref_clk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
        end
        repeat (60) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_bvalid & s_axi_bready
                | s_axi_rvalid & s_axi_rready) begin
                d = w ? d : s_axi_rdata;
                {s_axi_bready, s_axi_rready} <= 2'h0;
                return;
            end
            // ready comes late so the slave must hold its answer a cycle
            if (s_axi_bvalid) s_axi_bready <= 1'h1;
            if (s_axi_rvalid) s_axi_rready <= 1'h1;
        end
        hung <= 1'h1;
    endtask
endmodule

// ### verif/testbench.sv
// command sequences through the register port, checked on status
// assumes memory all erased and mode one after reset
`timescale 1ns/1ps
module testbench;
    import sza_pkg::*;
    logic              ref_clk = 1'h0;
    logic              rst = 1'h1;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, st;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready, hung;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic              s_axi_rready;
    logic [29:0]       e;
    int                num_errors = 0;
    int                checks_done = 0;
    // {pre count, op, pre ops compare, status bit (8 addr, 9 none), exp}
    logic [29:0] steps [0:26] = '{
        {11'h000, OP_RESET, 1'h0, 4'h8, 11'h000},
        {11'h010, OP_WRITE, 1'h0, 4'h5, 11'h001},
        {11'h000, OP_READ,  1'h0, 4'h4, 11'h001},
        {11'h040, OP_CMP,   1'h0, 4'h9, 11'h000},
        {11'h00e, OP_CMP,   1'h1, 4'h1, 11'h001},
        {11'h000, OP_RESET, 1'h0, 4'h9, 11'h000},
        {11'h010, OP_WRITE, 1'h0, 4'h5, 11'h000},
        {11'h000, OP_READ,  1'h0, 4'h4, 11'h000},
        {11'h3f6, OP_WRITE, 1'h0, 4'h5, 11'h000},
        {11'h000, OP_READ,  1'h0, 4'h4, 11'h000},
        {11'h000, OP_ERASE, 1'h0, 4'h5, 11'h000},
        {11'h000, OP_READ,  1'h0, 4'h4, 11'h001},
        {11'h000, OP_WRITE, 1'h0, 4'h9, 11'h000},
        {11'h1fa, OP_WRITE, 1'h0, 4'h3, 11'h001},
        {11'h000, OP_READ,  1'h0, 4'h7, 11'h001},
        {11'h000, OP_READ,  1'h0, 4'h6, 11'h001},
        {11'h010, OP_WRITE, 1'h0, 4'h5, 11'h001},
        {11'h01f, OP_WRITE, 1'h0, 4'h5, 11'h001},
        {11'h001, OP_ERASE, 1'h0, 4'h5, 11'h001},
        {11'h006, OP_WRITE, 1'h0, 4'h5, 11'h000},
        {11'h008, OP_INC,   1'h0, 4'h8, 11'h63f},
        {11'h000, OP_INC,   1'h0, 4'h8, 11'h000},
        {11'h406, OP_READ,  1'h0, 4'h4, 11'h000},
        {11'h229, OP_CMP,   1'h0, 4'h2, 11'h001},
        {11'h000, OP_ERASE, 1'h0, 4'h5, 11'h000},
        {11'h000, OP_RESET, 1'h0, 4'h9, 11'h000},
        {11'h406, OP_READ,  1'h0, 4'h4, 11'h001}
    };
    sza_access_ctrl DUT (.*);
    sza_rdr rdr (.*);
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // compare data is always one: every key bit is still erased
    task automatic op(input logic [2:0] o);
        st = {27'h0, 2'h2, o};
        rdr.xfer(1'h1, REG_CMD, st);
        repeat (3) @(posedge ref_clk);
        repeat (300) begin
            rdr.xfer(1'h0, REG_STATUS, st);
            if (st[ST_BUSY] === 1'h0) return;
        end
        num_errors++;
        give_verdict;
    endtask
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        wait (hung === 1'h1);
        num_errors++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'h0;
        rdr.xfer(1'h0, 12'h00c, st);
        chk(st, 32'h0);
        for (int i = 0; i < 27; i++) begin
            e = steps[i];
            repeat (e[29:19]) op(e[15] ? OP_CMP : OP_INC);
            op(e[18:16]);
            if (e[14:11] == 4'h8) begin
                rdr.xfer(1'h0, REG_ADDR, st);
                chk({21'h0, st[10:0]}, {21'h0, e[10:0]});
            end else if (e[14:11] != 4'h9)
                chk({31'h0, st[e[14:11]]}, {31'h0, e[0]});
        end
        give_verdict;
    end
endmodule
